// >>> src/bsd_cell_grade.sv
// grading of one backup cell into lamp drive and flag pair
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_cell_grade
   import bsd_pkg::*;
(
   input wire logic below_low_i,
   input wire logic below_bad_i,
   output bsd_cell_t grade_o,
   output logic low_o,
   output logic bad_o
);
   always_comb begin
      if (below_bad_i) begin
         grade_o = BSD_CELL_BAD;
      end else if (below_low_i) begin
         grade_o = BSD_CELL_LOW;
      end else begin
         grade_o = BSD_CELL_OK;
      end
      // bad implies low as well
      low_o = (grade_o != BSD_CELL_OK);
      bad_o = (grade_o == BSD_CELL_BAD);
   end
endmodule

// >>> src/bsd_map.svh
// register map, field positions and reset values of the battery status dio port
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
`define BSD_DIN_OFS 12'h000
`define BSD_DOUT_OFS 12'h004
`define BSD_ID_OFS 12'h008
`define BSD_SUBID_OFS 12'h00c
`define BSD_STAT_OFS 12'h010
`define BSD_MASK_OFS 12'h014
`define BSD_PRI_LOW_BIT 0
`define BSD_PRI_BAD_BIT 1
`define BSD_SEC_LOW_BIT 2
`define BSD_SEC_BAD_BIT 3
`define BSD_FLAG_W 4
`define BSD_DOUT_RST 16'h0000
`define BSD_MASK_RST 4'h0
`endif

// >>> src/bsd_pkg.sv
// types of the battery status dio port
package bsd_pkg;
   typedef enum logic [1:0] {
      BSD_CELL_OK,
      BSD_CELL_LOW,
      BSD_CELL_BAD
   } bsd_cell_t;
endpackage

// >>> src/bsd_port.sv
// battery status digital input/output port with ahb-lite register access
`timescale 1ns/1ps
`include "bsd_map.svh"
module bsd_port
   import bsd_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int FLAG_W = 4,
   parameter logic [15:0] VENDOR_CODE = 16'h1234,
   parameter logic [15:0] DEVICE_CODE = 16'h5678,
   parameter logic [15:0] SUB_VENDOR_CODE = 16'h9abc,
   parameter logic [15:0] SUB_DEVICE_CODE = 16'hdef0
)
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [11:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [DATA_W-1:FLAG_W] ext_in_i,
   input wire logic primary_below_low_i,
   input wire logic primary_below_bad_i,
   input wire logic secondary_below_low_i,
   input wire logic secondary_below_bad_i,
   output logic [DATA_W-1:0] dout_o,
   output logic primary_low_lamp_o,
   output logic primary_bad_lamp_o,
   output logic secondary_low_lamp_o,
   output logic secondary_bad_lamp_o,
   output logic irq_o
);
   // identity values above are arbitrary

   initial begin
      if (DATA_W != 16 || FLAG_W != `BSD_FLAG_W) begin
         $error("bsd_port: only a 16-bit port with 4 flag bits is supported");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cell grading

   logic pri_low, pri_bad, sec_low, sec_bad;
   bsd_cell_t pri_grade, sec_grade;

   bsd_cell_grade u_pri (
      .below_low_i(primary_below_low_i),
      .below_bad_i(primary_below_bad_i),
      .grade_o(pri_grade),
      .low_o(pri_low),
      .bad_o(pri_bad)
   );

   bsd_cell_grade u_sec (
      .below_low_i(secondary_below_low_i),
      .below_bad_i(secondary_below_bad_i),
      .grade_o(sec_grade),
      .low_o(sec_low),
      .bad_o(sec_bad)
   );

   logic [FLAG_W-1:0] flags;
   always_comb begin
      flags = '0;
      flags[`BSD_PRI_LOW_BIT] = pri_low;
      flags[`BSD_PRI_BAD_BIT] = pri_bad;
      flags[`BSD_SEC_LOW_BIT] = sec_low;
      flags[`BSD_SEC_BAD_BIT] = sec_bad;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [FLAG_W-1:0] lamp_ff, nxt_lamp;
   logic [DATA_W-1:0] din_ff, nxt_din;
   logic [DATA_W-1:0] dout_ff, nxt_dout;
   logic [FLAG_W-1:0] stat_ff, nxt_stat;
   logic [FLAG_W-1:0] mask_ff, nxt_mask;
   logic [FLAG_W-1:0] flags_ff, nxt_flags;
   logic [31:0] rdata_ff, nxt_rdata;
   logic wr_pend_ff, nxt_wr_pend;
   logic [11:0] wr_addr_ff, nxt_wr_addr;

   logic addr_ok;
   logic [31:0] rd_mux;
   logic [FLAG_W-1:0] w1c;

   always_comb begin
      addr_ok = hsel_i && hready_i && htrans_i[1];
      // lamps follow the grades; all dark when both cells are healthy
      nxt_lamp = flags;
      nxt_din = {ext_in_i, flags};
      nxt_flags = flags;
      unique case (haddr_i)
         `BSD_DIN_OFS: rd_mux = {16'h0000, din_ff};
         `BSD_DOUT_OFS: rd_mux = {16'h0000, dout_ff};
         `BSD_ID_OFS: rd_mux = {DEVICE_CODE, VENDOR_CODE};
         `BSD_SUBID_OFS: rd_mux = {SUB_DEVICE_CODE, SUB_VENDOR_CODE};
         `BSD_STAT_OFS: rd_mux = {28'h0000000, stat_ff};
         `BSD_MASK_OFS: rd_mux = {28'h0000000, mask_ff};
         default: rd_mux = 32'h00000000;
      endcase
      nxt_rdata = (addr_ok && !hwrite_i) ? rd_mux : rdata_ff;
      nxt_wr_pend = addr_ok && hwrite_i;
      nxt_wr_addr = addr_ok ? haddr_i : wr_addr_ff;
      nxt_dout = dout_ff;
      nxt_mask = mask_ff;
      w1c = '0;
      if (wr_pend_ff) begin
         if (wr_addr_ff == `BSD_DOUT_OFS) begin
            nxt_dout = hwdata_i[DATA_W-1:0];
         end
         if (wr_addr_ff == `BSD_MASK_OFS) begin
            nxt_mask = hwdata_i[FLAG_W-1:0];
         end
         if (wr_addr_ff == `BSD_STAT_OFS) begin
            w1c = hwdata_i[FLAG_W-1:0];
         end
      end
      // a rising flag in the clearing cycle wins over the clear
      nxt_stat = (stat_ff & ~w1c) | (flags & ~flags_ff);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lamp_ff <= '0;
         din_ff <= '0;
         dout_ff <= `BSD_DOUT_RST;
         stat_ff <= '0;
         mask_ff <= `BSD_MASK_RST;
         flags_ff <= '0;
         rdata_ff <= 32'h00000000;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
      end else begin
         lamp_ff <= nxt_lamp;
         din_ff <= nxt_din;
         dout_ff <= nxt_dout;
         stat_ff <= nxt_stat;
         mask_ff <= nxt_mask;
         flags_ff <= nxt_flags;
         rdata_ff <= nxt_rdata;
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign hrdata_o = rdata_ff;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign dout_o = dout_ff;
   assign primary_low_lamp_o = lamp_ff[`BSD_PRI_LOW_BIT];
   assign primary_bad_lamp_o = lamp_ff[`BSD_PRI_BAD_BIT];
   assign secondary_low_lamp_o = lamp_ff[`BSD_SEC_LOW_BIT];
   assign secondary_bad_lamp_o = lamp_ff[`BSD_SEC_BAD_BIT];
   assign irq_o = |(stat_ff & mask_ff);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   // a write data phase to one offset is under way
   function automatic logic wr_hit(input logic [11:0] ofs);
      return wr_pend_ff && (wr_addr_ff == ofs);
   endfunction

   a_pri_grade_legal: assert property (@(posedge core_clk_i) disable iff (rst_i)
      pri_grade inside {BSD_CELL_OK, BSD_CELL_LOW, BSD_CELL_BAD})
      else $error("primary grade illegal");

   a_sec_grade_legal: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sec_grade inside {BSD_CELL_OK, BSD_CELL_LOW, BSD_CELL_BAD})
      else $error("secondary grade illegal");

   a_pri_low_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !primary_below_low_i && !primary_below_bad_i |=> !primary_low_lamp_o && !din_ff[0])
      else $error("primary low lamp lit without cause");

   a_pri_bad_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !primary_below_bad_i |=> !primary_bad_lamp_o && !din_ff[1])
      else $error("primary bad lamp lit without cause");

   a_sec_low_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !secondary_below_low_i && !secondary_below_bad_i |=> !secondary_low_lamp_o && !din_ff[2])
      else $error("secondary low lamp lit without cause");

   a_sec_bad_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !secondary_below_bad_i |=> !secondary_bad_lamp_o && !din_ff[3])
      else $error("secondary bad lamp lit without cause");

   a_pri_bad_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      primary_bad_lamp_o |-> primary_low_lamp_o)
      else $error("primary bad lamp without low lamp");

   a_sec_bad_low: assert property (@(posedge core_clk_i) disable iff (rst_i)
      secondary_bad_lamp_o |-> secondary_low_lamp_o)
      else $error("secondary bad lamp without low lamp");

   a_lamp_flag_match: assert property (@(posedge core_clk_i) disable iff (rst_i)
      din_ff[3:0] == {secondary_bad_lamp_o, secondary_low_lamp_o, primary_bad_lamp_o,
      primary_low_lamp_o})
      else $error("lamps and flag bits disagree");

   a_ready_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
      hreadyout_o)
      else $error("wait state inserted");

   a_resp_okay: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !hresp_o)
      else $error("error response given");

   a_din_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && !hwrite_i && haddr_i == `BSD_DIN_OFS |=> hrdata_o == {16'h0000, $past(din_ff)})
      else $error("input word read wrong");

   a_dout_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && !hwrite_i && haddr_i == `BSD_DOUT_OFS |=> hrdata_o == {16'h0000, $past(dout_ff)})
      else $error("output word read wrong");

   a_subid_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && !hwrite_i && haddr_i == `BSD_SUBID_OFS
      |=> hrdata_o == {SUB_DEVICE_CODE, SUB_VENDOR_CODE})
      else $error("subsystem identity read wrong");

   a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && !hwrite_i && !(haddr_i inside {`BSD_DIN_OFS, `BSD_DOUT_OFS, `BSD_ID_OFS,
      `BSD_SUBID_OFS, `BSD_STAT_OFS, `BSD_MASK_OFS}) |=> hrdata_o == 32'h00000000)
      else $error("unmapped read not zero");

   a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(addr_ok && !hwrite_i) |=> $stable(hrdata_o))
      else $error("read data changed without a read");

   a_wr_capture: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && hwrite_i |=> wr_pend_ff && wr_addr_ff == $past(haddr_i))
      else $error("write address phase missed");

   a_no_wr_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(addr_ok && hwrite_i) |=> !wr_pend_ff)
      else $error("write data phase without address phase");

   a_mask_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_hit(`BSD_MASK_OFS) |=> mask_ff == $past(hwdata_i[3:0]))
      else $error("mask write missed");

   a_mask_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !wr_hit(`BSD_MASK_OFS) |=> $stable(mask_ff))
      else $error("mask changed without a write");

   a_stat_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (flags & ~flags_ff) != 4'h0
      |=> (stat_ff & $past(flags & ~flags_ff)) == $past(flags & ~flags_ff))
      else $error("status bit not set on rising flag");

   a_stat_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_hit(`BSD_STAT_OFS) |=> (stat_ff & $past(hwdata_i[3:0] & ~(flags & ~flags_ff))) == 4'h0)
      else $error("status bit not cleared by write");

   a_stat_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !wr_hit(`BSD_STAT_OFS) && (flags & ~flags_ff) == 4'h0 |=> $stable(stat_ff))
      else $error("status changed without cause");

   a_pri_low_lamp: assert property (@(posedge core_clk_i) disable iff (rst_i)
      primary_below_low_i |=> primary_low_lamp_o && din_ff[`BSD_PRI_LOW_BIT])
      else $error("primary low lamp not lit");
   a_pri_bad_both: assert property (@(posedge core_clk_i) disable iff (rst_i)
      primary_below_bad_i |=> primary_low_lamp_o && primary_bad_lamp_o && din_ff[1:0] == 2'h3)
      else $error("primary bad lamps or flags wrong");
   a_sec_low_lamp: assert property (@(posedge core_clk_i) disable iff (rst_i)
      secondary_below_low_i |=> secondary_low_lamp_o && din_ff[`BSD_SEC_LOW_BIT])
      else $error("secondary low lamp not lit");
   a_sec_bad_both: assert property (@(posedge core_clk_i) disable iff (rst_i)
      secondary_below_bad_i |=> secondary_low_lamp_o && secondary_bad_lamp_o
      && din_ff[3:2] == 2'h3)
      else $error("secondary bad lamps or flags wrong");
   a_healthy_dark: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(primary_below_low_i || primary_below_bad_i || secondary_below_low_i
      || secondary_below_bad_i) |=> din_ff[3:0] == 4'h0 && !primary_low_lamp_o
      && !primary_bad_lamp_o && !secondary_low_lamp_o && !secondary_bad_lamp_o)
      else $error("lamps or flags set with healthy cells");
   a_ext_mirror: assert property (@(posedge core_clk_i) disable iff (rst_i)
      1'b1 |=> din_ff[DATA_W-1:FLAG_W] == $past(ext_in_i))
      else $error("external input bits not mirrored");
   a_dout_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !(wr_pend_ff && wr_addr_ff == `BSD_DOUT_OFS) |=> $stable(dout_o))
      else $error("output port changed without a write");
   a_dout_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
      wr_pend_ff && wr_addr_ff == `BSD_DOUT_OFS |=> dout_o == $past(hwdata_i[15:0]))
      else $error("output port missed a write");
   a_id_read: assert property (@(posedge core_clk_i) disable iff (rst_i)
      addr_ok && !hwrite_i && haddr_i == `BSD_ID_OFS
      |=> hrdata_o == {DEVICE_CODE, VENDOR_CODE})
      else $error("identity read wrong");
endmodule

// >>> tb/battery_status_dio_port_tb.sv
// bench of the battery status dio port
`timescale 1ns/1ps
module battery_status_dio_port_tb;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hrdy, irq, hresp;
   logic [11:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic [31:0] hwdata = '0, hrdata, rd;
   logic [15:4] ext = 12'ha5c;
   logic [15:0] dout;
   logic [3:0] lamp, blw;
   int pri_mv = 2500, sec_mv = 2500, n_mismatch = 0, total_checks = 0;
   int mv[3] = '{2500, 2200, 2000};
   logic [3:0] fl[3] = '{4'h0, 4'h1, 4'h3};
   always #2.5 clk = ~clk;
   bsd_cells cells_u (.pri_mv_i(pri_mv), .sec_mv_i(sec_mv), .pri_low_o(blw[0]),
      .pri_bad_o(blw[1]), .sec_low_o(blw[2]), .sec_bad_o(blw[3]));
   // identity values are arbitrary
   bsd_port #(.VENDOR_CODE(16'h1111), .DEVICE_CODE(16'h2222), .SUB_VENDOR_CODE(16'h3333),
      .SUB_DEVICE_CODE(16'h4444)) dut_u (.core_clk_i(clk), .rst_i(rst), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
      .hresp_o(hresp), .ext_in_i(ext), .primary_below_low_i(blw[0]),
      .primary_below_bad_i(blw[1]), .secondary_below_low_i(blw[2]),
      .secondary_below_bad_i(blw[3]), .dout_o(dout), .primary_low_lamp_o(lamp[0]),
      .primary_bad_lamp_o(lamp[1]), .secondary_low_lamp_o(lamp[2]),
      .secondary_bad_lamp_o(lamp[3]), .irq_o(irq));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #20000;
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({dout, lamp, irq}, '0);
      $display("reset test done");
      xfer(12'h004, 1'b1, 32'h5555);
      xfer(12'h004, 1'b0, 32'h0);
      chk(rd, 32'h5555);
      chk(dout, 16'h5555);
      xfer(12'h000, 1'b0, 32'h0);
      xfer(12'h004, 1'b1, 32'haaaa);
      @(posedge clk);
      chk(dout, 16'haaaa);
      $display("output test done");
      xfer(12'h008, 1'b0, 32'h0);
      chk(rd, 32'h22221111);
      xfer(12'h00c, 1'b0, 32'h0);
      chk(rd, 32'h44443333);
      chk(hresp, 1'b0);
      xfer(12'h100, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("id test done");
      for (int i = 0; i < 6; i++) begin
         pri_mv <= (i < 3) ? mv[i] : 2500;
         sec_mv <= (i < 3) ? 2500 : mv[i - 3];
         ext <= ext ^ 12'h3c3;
         repeat (3) @(posedge clk);
         xfer(12'h000, 1'b0, 32'h0);
         chk(rd, {16'h0, ext, (i < 3) ? fl[i] : fl[i - 3] << 2});
         chk(lamp, (i < 3) ? fl[i] : fl[i - 3] << 2);
      end
      $display("cell test done");
      xfer(12'h010, 1'b0, 32'h0);
      chk(rd, 32'hf);
      chk(irq, 1'b0);
      xfer(12'h014, 1'b1, 32'h2);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1);
      xfer(12'h010, 1'b1, 32'h2);
      xfer(12'h010, 1'b0, 32'h0);
      chk(rd, 32'hd);
      chk(irq, 1'b0);
      $display("interrupt test done");
      close_out();
   end
endmodule

// >>> tb/bsd_cells.sv
// model of the two backup cells and their threshold comparators
`timescale 1ns/1ps
module bsd_cells (
   input int pri_mv_i,
   input int sec_mv_i,
   output logic pri_low_o,
   output logic pri_bad_o,
   output logic sec_low_o,
   output logic sec_bad_o
);
   // levels below 2300 mv read low, below 2100 mv read bad
   assign pri_low_o = pri_mv_i < 2300;
   assign pri_bad_o = pri_mv_i < 2100;
   assign sec_low_o = sec_mv_i < 2300;
   assign sec_bad_o = sec_mv_i < 2100;
endmodule
